// ===== rtl/fault_mon_pkg.sv
// Package for the motor and bias fault monitor: timing constants, fault codes,
// and the struct that carries bias status.
// Assumes a 20 MHz system clock; times are given in milliseconds.
package fault_mon_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;

  // Qualification times in milliseconds
  localparam int unsigned START_MS      = 1000;
  localparam int unsigned STALL_MS      = 2000;
  localparam int unsigned BIAS_MS       = 500;

  // Derived cycle counts
  localparam int unsigned START_CYC     = START_MS * CYC_PER_MS;
  localparam int unsigned STALL_CYC     = STALL_MS * CYC_PER_MS;
  localparam int unsigned BIAS_CYC      = BIAS_MS * CYC_PER_MS;

  // Motor count and widths
  localparam int unsigned NUM_MOTORS    = 3;
  localparam int unsigned CODE_W        = 4;
  localparam int unsigned DUTY_W        = 8;

  // Fault codes: zero means no fault, motors are 1..N, bias gets its own
  localparam logic [3:0] CODE_NONE      = 4'h0;
  localparam logic [3:0] CODE_MOTOR0    = 4'h1;
  localparam logic [3:0] CODE_BIAS      = 4'hF;

  // Reset values
  localparam logic [2:0] FAULT_RST      = 3'h0;

  // Bias status sample from the high-voltage supply
  typedef struct packed {
    logic             output_on;   // Bias output switched on
    logic             printing;    // Printing cycle in progress
    logic             volt_high;   // Feedback voltage at or above threshold
    logic [7:0]       duty;        // Commanded PWM duty, full scale 8'hFF
  } bias_stat_t;

endpackage

// ===== rtl/motor_bias_fault_monitor.sv
// Motor lock and transfer bias fault monitor.
// Pins from the motor drive boards and the bias supply are asynchronous and
// pass two flip-flops first. Fault codes are read by logic on sys_clk.
`timescale 1ns/1ns
module motor_bias_fault_monitor #(
  parameter int unsigned NUM_MOTORS = fault_mon_pkg::NUM_MOTORS,
  parameter int unsigned START_CYC  = fault_mon_pkg::START_CYC,
  parameter int unsigned STALL_CYC  = fault_mon_pkg::STALL_CYC,
  parameter int unsigned BIAS_CYC   = fault_mon_pkg::BIAS_CYC
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Motor drive pins, asynchronous
  input  wire logic [NUM_MOTORS-1:0]         motor_trigger,
  input  wire logic [NUM_MOTORS-1:0]         motor_fb_ok,
  // Bias supply status, asynchronous
  input  wire fault_mon_pkg::bias_stat_t     bias_stat,
  // Fault status to the controller
  output logic [NUM_MOTORS-1:0]              motor_fault,
  output logic                               bias_fault,
  output logic [fault_mon_pkg::CODE_W-1:0]   fault_code
);

  // Timer widths; the start timer stops one past its mark, hence the extra count
  localparam int unsigned SW = $clog2(START_CYC + 2);
  localparam int unsigned CW = $clog2(STALL_CYC + 1);
  localparam int unsigned BW = $clog2(BIAS_CYC + 1);
  localparam int unsigned TW = (SW > CW) ? ((SW > BW) ? SW : BW) : ((CW > BW) ? CW : BW);

  // Timer limits at the shared arithmetic width
  localparam logic [TW-1:0] START_LIM = TW'(START_CYC + 1);
  localparam logic [TW-1:0] STALL_LIM = TW'(STALL_CYC);
  localparam logic [TW-1:0] BIAS_LIM  = TW'(BIAS_CYC);

  // Half scale of the commanded duty
  localparam logic [fault_mon_pkg::DUTY_W-1:0] DUTY_HALF = 8'h80;

  // Saturating increment used by every timer; holding at the limit keeps a
  // long stall from wrapping round and clearing its own trip
  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v,
                                            input logic [TW-1:0] lim);
    sat_inc = (v >= lim) ? lim : v + 1'b1;
  endfunction

  // Next value of a bias run timer: counts while its condition holds, else zero
  function automatic logic [BW-1:0] run_next(input logic          hold,
                                             input logic [BW-1:0] cur);
    run_next = hold ? BW'(sat_inc(TW'(cur), BIAS_LIM)) : '0;
  endfunction

  // Code of the first fault; the lowest motor wins a tie and the bias comes last
  function automatic logic [fault_mon_pkg::CODE_W-1:0] first_code(
    input logic [NUM_MOTORS-1:0] motors,
    input logic                  bias);
    first_code = bias ? fault_mon_pkg::CODE_BIAS : fault_mon_pkg::CODE_NONE;
    for (int i = NUM_MOTORS - 1; i >= 0; i--)
    begin
      if (motors[i])
        first_code = fault_mon_pkg::CODE_MOTOR0 + 4'(i);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [NUM_MOTORS-1:0]     trig_s1_reg;
  logic [NUM_MOTORS-1:0]     trig_reg;
  logic [NUM_MOTORS-1:0]     fb_s1_reg;
  logic [NUM_MOTORS-1:0]     fb_reg;
  fault_mon_pkg::bias_stat_t bias_s1_reg;
  fault_mon_pkg::bias_stat_t bias_reg;

  // Two stages on every pin; only the second stage is read
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      trig_s1_reg <= '0;
      trig_reg    <= '0;
      fb_s1_reg   <= '0;
      fb_reg      <= '0;
      bias_s1_reg <= '0;
      bias_reg    <= '0;
    end
    else
    begin
      trig_s1_reg <= motor_trigger;
      trig_reg    <= trig_s1_reg;
      fb_s1_reg   <= motor_fb_ok;
      fb_reg      <= fb_s1_reg;
      bias_s1_reg <= bias_stat;
      bias_reg    <= bias_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Motor timers

  logic [SW-1:0]         since_trig_reg [NUM_MOTORS];
  logic [CW-1:0]         bad_run_reg    [NUM_MOTORS];
  logic [NUM_MOTORS-1:0] start_trip;
  logic [NUM_MOTORS-1:0] stall_trip;
  logic [NUM_MOTORS-1:0] motor_trip;

  // Time since the trigger was seen high; it stops one past the start mark, so
  // the start check fires on one cycle only and later spells go to the stall timer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_MOTORS; i++)
      begin
        since_trig_reg[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_MOTORS; i++)
      begin
        if (!trig_reg[i])
          since_trig_reg[i] <= '0;  // A new start gets a fresh window
        else
          since_trig_reg[i] <= SW'(sat_inc(TW'(since_trig_reg[i]), START_LIM));
      end
    end
  end

  // Length of the current out-of-range run; any good sample or a dropped
  // trigger starts it again
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_MOTORS; i++)
      begin
        bad_run_reg[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_MOTORS; i++)
      begin
        if (!trig_reg[i] || fb_reg[i])
          bad_run_reg[i] <= '0;
        else
          bad_run_reg[i] <= CW'(sat_inc(TW'(bad_run_reg[i]), STALL_LIM));
      end
    end
  end

  // Trip decode: the start check looks once, at the mark; the run check
  // fires while a full bad run is still bad
  always_comb
  begin
    for (int i = 0; i < NUM_MOTORS; i++)
    begin
      start_trip[i] = trig_reg[i] && !fb_reg[i]
                      && (since_trig_reg[i] == SW'(START_CYC));
      stall_trip[i] = trig_reg[i] && !fb_reg[i]
                      && (bad_run_reg[i] == CW'(STALL_CYC));
    end
  end

  assign motor_trip = start_trip | stall_trip;

  ////////////////////////////////////////////////////////////////////////////
  // Bias timers

  logic          bias_active;
  logic [BW-1:0] volt_run_reg;
  logic [BW-1:0] duty_run_reg;
  logic          bias_trip;

  // Outside an active print with bias on, both timers are held at zero
  assign bias_active = bias_reg.output_on && bias_reg.printing;

  // Feedback voltage run; a single low sample starts the count again
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      volt_run_reg <= '0;
    else
      volt_run_reg <= run_next(bias_active && bias_reg.volt_high, volt_run_reg);
  end

  // Duty run, kept apart from the voltage run so neither masks the other
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      duty_run_reg <= '0;
    else
      duty_run_reg <= run_next(bias_active && (bias_reg.duty >= DUTY_HALF),
                               duty_run_reg);
  end

  assign bias_trip = (volt_run_reg == BW'(BIAS_CYC)) || (duty_run_reg == BW'(BIAS_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches and code

  // Flags are sticky until reset; a later fault still shows in its own flag
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      motor_fault <= '0;
      bias_fault  <= 1'b0;
    end
    else
    begin
      motor_fault <= motor_fault | motor_trip;
      bias_fault  <= bias_fault | bias_trip;
    end
  end

  // The code records the first fault only, so the controller sees the cause
  // and not a follow-on effect
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      fault_code <= fault_mon_pkg::CODE_NONE;
    else if (fault_code == fault_mon_pkg::CODE_NONE)
      fault_code <= first_code(motor_trip, bias_trip);
  end

endmodule

// ===== tb/fault_mon_assertions.sv
// Checker on the fault monitor ports.
// Assumes each cause is held steady for several cycles before its fault.
`timescale 1ns/1ns
module fault_mon_assertions #(
  parameter int unsigned NUM_MOTORS = 3
) (
  // Clock and reset
  input wire logic                      sys_clk,
  input wire logic                      rst,
  // Pins and status
  input wire logic [NUM_MOTORS-1:0]     motor_trigger,
  input wire logic [NUM_MOTORS-1:0]     motor_fb_ok,
  input wire fault_mon_pkg::bias_stat_t bias_stat,
  input wire logic [NUM_MOTORS-1:0]     motor_fault,
  input wire logic                      bias_fault,
  input wire logic [3:0]                fault_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Fresh trigger on an idle motor; counts are long, so no fault soon after
  sequence s_trig_start;
    !motor_trigger[0] && !motor_fault[0] ##1 motor_trigger[0];
  endsequence
  a_lock_not_early: assert property (s_trig_start |-> !motor_fault[0] [*8])
    else $error("motor fault too soon");
  a_stall_cause: assert property ($rose(motor_fault[1]) |->
    $past(motor_trigger[1] && !motor_fb_ok[1], 3)) else $error("motor fault without cause");
  a_bias_gate: assert property ($rose(bias_fault) |->
    $past(bias_stat.output_on && bias_stat.printing, 4)) else $error("bias fault while idle");
  a_bias_cause: assert property ($rose(bias_fault) |->
    $past(bias_stat.volt_high || bias_stat.duty[7], 4)) else $error("bias fault without cause");
  a_code_hold: assert property (fault_code != 4'h0 |=> $stable(fault_code))
    else $error("fault code changed");
  a_flag_sticky: assert property (bias_fault || motor_fault != 3'h0 |=>
    bias_fault >= $past(bias_fault) && (motor_fault & $past(motor_fault)) == $past(motor_fault))
    else $error("fault flag dropped");
  // Code and flags are set on the same edge, so a code means a flag is up
  a_code_flags: assert property ((fault_code == 4'h0) == !(|motor_fault || bias_fault))
    else $error("fault code and flags disagree");
endmodule

// ===== tb/motor_bias_fault_monitor_test.sv
// Self-checking bench for the fault monitor, with short qualification counts.
// Assumes the board model and checker are compiled first.
`timescale 1ns/1ns
module motor_bias_fault_monitor_test;
  localparam int unsigned N_START = 20;
  localparam int unsigned N_STALL = 40;
  localparam int unsigned N_BIAS  = 10;
  logic                      sys_clk = 1'b0;
  logic                      rst = 1'b1;
  logic [2:0]                motor_trigger = 3'h0;
  logic [2:0]                stall = 3'h0;
  logic [2:0]                motor_fb_ok;
  logic [2:0]                motor_fault;
  logic                      bias_fault;
  logic [3:0]                fault_code;
  fault_mon_pkg::bias_stat_t bias_stat = 11'h000;
  int                        miscompares = 0;
  int                        n_checks = 0;
  wire  [7:0]                st = {motor_fault, bias_fault, fault_code};
  motor_board_model board (.sys_clk(sys_clk), .motor_trigger(motor_trigger), .stall(stall),
    .motor_fb_ok(motor_fb_ok));
  motor_bias_fault_monitor #(.NUM_MOTORS(3), .START_CYC(N_START), .STALL_CYC(N_STALL),
    .BIAS_CYC(N_BIAS)) dut
    (.sys_clk(sys_clk), .rst(rst), .motor_trigger(motor_trigger), .motor_fb_ok(motor_fb_ok),
    .bias_stat(bias_stat), .motor_fault(motor_fault), .bias_fault(bias_fault),
    .fault_code(fault_code));
  // Clock, 50 ns period
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error status expected %h seen %h", exp, got);
    end
  endtask
  // Idle until just short of the count, then a bounded wait for the flag
  task automatic wait_flag(input int lo, input logic [7:0] exp);
    repeat (lo) @(negedge sys_clk);
    check(8'h00, st);
    for (int k = 0; k < 8 && st === 8'h00; k++) @(negedge sys_clk);
    check(exp, st);
  endtask
  task automatic reset_all;
    @(negedge sys_clk);
    rst = 1'b1;
    motor_trigger = 3'h0;
    stall = 3'h0;
    bias_stat = 11'h000;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
  endtask
  task automatic t_start;
    reset_all();
    repeat (2) @(negedge sys_clk);
    stall = 3'h5;
    motor_trigger = 3'h5;
    wait_flag(N_START - 1, 8'hA1);
    motor_trigger = 3'h0;
    bias_stat = 11'h700;
    repeat (N_BIAS + 8) @(negedge sys_clk);
    check(8'hB1, st);
    $display("t_start done");
  endtask
  // A short bad run is forgiven; a full one is not
  task automatic t_stall;
    reset_all();
    motor_trigger = 3'h2;
    repeat (N_START + 8) @(negedge sys_clk);
    stall = 3'h2;
    wait_flag(N_STALL - 14, 8'h00);
    stall = 3'h0;
    repeat (4) @(negedge sys_clk);
    stall = 3'h2;
    wait_flag(N_STALL - 1, 8'h42);
    $display("t_stall done");
  endtask
  task automatic bias_case(input logic [10:0] stat, input logic [7:0] exp);
    reset_all();
    bias_stat = stat;
    wait_flag(N_BIAS - 1, exp);
    $display("bias case %h done", stat);
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    t_start();
    t_stall();
    bias_case(11'h5FF, 8'h00);
    bias_case(11'h3FF, 8'h00);
    bias_case(11'h700, 8'h1F);
    bias_case(11'h67F, 8'h00);
    bias_case(11'h680, 8'h1F);
    give_verdict();
  end
endmodule
bind motor_bias_fault_monitor fault_mon_assertions #(.NUM_MOTORS(NUM_MOTORS)) chk (
  .sys_clk(sys_clk), .rst(rst), .motor_trigger(motor_trigger), .motor_fb_ok(motor_fb_ok),
  .bias_stat(bias_stat), .motor_fault(motor_fault), .bias_fault(bias_fault),
  .fault_code(fault_code));

// ===== tb/motor_board_model.sv
// Motor drive board model: feedback is good one clock after the trigger is raised.
// Assumes trigger comes from the bench; stall forces feedback out of range.
`timescale 1ns/1ns
module motor_board_model (
  // Clock and pins
  input  wire logic       sys_clk,
  input  wire logic [2:0] motor_trigger,
  input  wire logic [2:0] stall,
  output logic      [2:0] motor_fb_ok
);
  // A stopped motor reports out of range, so fb needs the trigger held
  always_ff @(posedge sys_clk)
  begin
    motor_fb_ok <= motor_trigger & ~stall;
  end
endmodule
